// ==== rtl/lddfr_pkg.sv ====
package lddfr_pkg;

   // ----------------------------------------
   // register indices, byte address = 4 * index
   // ----------------------------------------
   localparam int IDX_W = 14;
   localparam logic [IDX_W-1:0] IDX_NUM = 14'h0716;
   localparam logic [IDX_W-1:0] IDX_DEN = 14'h071D;
   localparam logic [IDX_W-1:0] IDX_UPD = 14'h0721;
   localparam logic [IDX_W-1:0] IDX_FRAC = 14'h0722;
   localparam logic [IDX_W-1:0] IDX_SMASK = 14'h0723;
   localparam logic [IDX_W-1:0] IDX_STEP = 14'h0724;
   localparam logic [IDX_W-1:0] IDX_INSEL = 14'h072B;
   localparam logic [IDX_W-1:0] IDX_FAST = 14'h072C;
   localparam logic [IDX_W-1:0] IDX_SELCTL = 14'h0740;
   localparam logic [IDX_W-1:0] IDX_STATUS = 14'h0741;

   // ----------------------------------------
   // byte window and field layout
   // ----------------------------------------
   localparam int NB = 23;
   localparam int NUM_BYTES = 7;
   localparam int DEN_BYTES = 4;
   localparam int STEP_BYTES = 7;
   localparam int NUM_W = 56;
   localparam int DEN_W = 32;
   localparam int UPD_BIT = 0;
   localparam int FRAC_MODE_LSB = 0;
   localparam int FRAC_MODE_W = 4;
   localparam int FRAC_EN_BIT = 4;
   localparam int SMASK_BIT = 0;
   localparam int INSEL_W = 3;
   localparam int AUTO_BIT = 0;
   localparam int FORCE_BIT = 1;
   localparam int SELCTL_BIT = 0;
   localparam int ST_FAST_BIT = 0;
   localparam int ST_INSEL_LSB = 1;
   localparam int ST_LOL_BIT = 3;

   // writable bits of each byte, index 0 is IDX_NUM
   localparam logic [NB-1:0][7:0] WR_MASK = {
      8'h03, 8'h07,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'h01, 8'h3F, 8'h00,
      8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef struct packed {
      logic [NUM_W-1:0] numerator;
      logic [DEN_W-1:0] denominator;
   } lddfr_divider_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_READ = 1'b1
   } lddfr_bus_state_t;

endpackage : lddfr_pkg

// ==== rtl/lddfr_top.sv ====
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module lddfr_top (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic soft_reset_req,
   input wire logic loss_of_lock,
   input wire logic [1:0] input_select_pins,
   input wire logic frequency_increment,
   input wire logic frequency_decrement,
   output lddfr_pkg::lddfr_divider_t active_divider,
   output logic [3:0] fractional_mode_field,
   output logic fractional_enable,
   output logic [1:0] selected_input,
   output logic fast_bandwidth
);

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [7:0] cfg_byte [lddfr_pkg::NB];
   logic register_select_control_reg;
   lddfr_pkg::lddfr_divider_t active_reg;
   lddfr_pkg::lddfr_bus_state_t bus_state_reg;
   logic [lddfr_pkg::IDX_W-1:0] rd_idx_reg;
   logic [lddfr_pkg::IDX_W-1:0] wr_idx_reg;
   logic wr_pend_reg;
   logic upd_pend_reg;
   logic [31:0] hrdata_reg;
   logic hready_reg;
   logic hresp_reg;
   logic [1:0] in_sel_reg;
   logic fast_bw_reg;
   logic [3:0] frac_mode_reg;
   logic frac_en_reg;

   logic [lddfr_pkg::NUM_W-1:0] staged_num;
   logic [lddfr_pkg::DEN_W-1:0] staged_den;
   logic [lddfr_pkg::NUM_W-1:0] step_word;
   logic [7:0] frac_byte;
   logic step_masked;
   logic [lddfr_pkg::INSEL_W-1:0] manual_input_select;
   logic auto_fast_acquire_enable;
   logic force_fast_acquire;
   logic addr_take;
   logic [lddfr_pkg::IDX_W-1:0] addr_idx;
   logic wr_hit_upd;
   logic [31:0] rd_next;

   // ----------------------------------------
   // ahb address phase
   // ----------------------------------------
   assign addr_take = hsel && hready && (htrans == lddfr_pkg::HTRANS_NONSEQ);
   assign addr_idx = haddr[lddfr_pkg::IDX_W+1:2];

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg <= '0;
      end
      else
      begin
         wr_pend_reg <= addr_take && hwrite;
         if (addr_take && hwrite)
         begin
            wr_idx_reg <= addr_idx;
         end
      end
   end

   // reads wait one cycle so a write just before is already stored
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         bus_state_reg <= lddfr_pkg::BUS_IDLE;
         rd_idx_reg <= '0;
         hready_reg <= 1'b1;
         hrdata_reg <= lddfr_pkg::WORD_ZERO;
      end
      else
      begin
         case (bus_state_reg)
            lddfr_pkg::BUS_IDLE:
            begin
               if (addr_take && !hwrite)
               begin
                  bus_state_reg <= lddfr_pkg::BUS_READ;
                  rd_idx_reg <= addr_idx;
                  hready_reg <= 1'b0;
               end
            end
            lddfr_pkg::BUS_READ:
            begin
               bus_state_reg <= lddfr_pkg::BUS_IDLE;
               hrdata_reg <= rd_next;
               hready_reg <= 1'b1;
            end
            default:
            begin
               bus_state_reg <= lddfr_pkg::BUS_IDLE;
               hready_reg <= 1'b1;
            end
         endcase
      end
   end

   // always OKAY, unmapped reads return zero
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         hresp_reg <= lddfr_pkg::HRESP_OKAY;
      end
      else
      begin
         hresp_reg <= lddfr_pkg::HRESP_OKAY;
      end
   end

   // ----------------------------------------
   // byte registers
   // ----------------------------------------
   for (genvar k = 0; k < lddfr_pkg::NB; k++)
   begin : g_byte
      always_ff @(posedge mclk or negedge nrst)
      begin
         if (!nrst)
         begin
            cfg_byte[k] <= lddfr_pkg::BYTE_RST;
         end
         else if (wr_pend_reg && (wr_idx_reg == lddfr_pkg::IDX_NUM + lddfr_pkg::IDX_W'(k)))
         begin
            cfg_byte[k] <= hwdata[7:0] & lddfr_pkg::WR_MASK[k];
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         register_select_control_reg <= 1'b0;
      end
      else if (wr_pend_reg && (wr_idx_reg == lddfr_pkg::IDX_SELCTL))
      begin
         register_select_control_reg <= hwdata[lddfr_pkg::SELCTL_BIT];
      end
   end

   // ----------------------------------------
   // field views of the byte window
   // ----------------------------------------
   always_comb
   begin
      staged_num = '0;
      staged_den = '0;
      step_word = '0;
      for (int i = 0; i < lddfr_pkg::NUM_BYTES; i++)
      begin
         staged_num[i*8 +: 8] = cfg_byte[int'(lddfr_pkg::IDX_NUM - lddfr_pkg::IDX_NUM) + i];
      end
      for (int i = 0; i < lddfr_pkg::DEN_BYTES; i++)
      begin
         staged_den[i*8 +: 8] = cfg_byte[int'(lddfr_pkg::IDX_DEN - lddfr_pkg::IDX_NUM) + i];
      end
      for (int i = 0; i < lddfr_pkg::STEP_BYTES; i++)
      begin
         step_word[i*8 +: 8] = cfg_byte[int'(lddfr_pkg::IDX_STEP - lddfr_pkg::IDX_NUM) + i];
      end
   end

   assign frac_byte = cfg_byte[int'(lddfr_pkg::IDX_FRAC - lddfr_pkg::IDX_NUM)];
   assign step_masked = cfg_byte[int'(lddfr_pkg::IDX_SMASK - lddfr_pkg::IDX_NUM)][lddfr_pkg::SMASK_BIT];
   assign manual_input_select = cfg_byte[int'(lddfr_pkg::IDX_INSEL - lddfr_pkg::IDX_NUM)][lddfr_pkg::INSEL_W-1:0];
   assign auto_fast_acquire_enable = cfg_byte[int'(lddfr_pkg::IDX_FAST - lddfr_pkg::IDX_NUM)][lddfr_pkg::AUTO_BIT];
   assign force_fast_acquire = cfg_byte[int'(lddfr_pkg::IDX_FAST - lddfr_pkg::IDX_NUM)][lddfr_pkg::FORCE_BIT];

   // ----------------------------------------
   // divider update strobe
   // ----------------------------------------
   assign wr_hit_upd = wr_pend_reg && (wr_idx_reg == lddfr_pkg::IDX_UPD) && hwdata[lddfr_pkg::UPD_BIT];

   // strobe lives one cycle, so a read nearly always sees zero
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         upd_pend_reg <= 1'b0;
      end
      else
      begin
         upd_pend_reg <= wr_hit_upd;
      end
   end

   // ----------------------------------------
   // operating divider
   // ----------------------------------------
   // a load beats a step in the same cycle; inc with dec cancels
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         active_reg <= '0;
      end
      else if (upd_pend_reg || soft_reset_req)
      begin
         active_reg.numerator <= staged_num;
         active_reg.denominator <= staged_den;
      end
      else if (!step_masked && (frequency_increment != frequency_decrement))
      begin
         if (frequency_increment)
         begin
            active_reg.numerator <= active_reg.numerator + step_word;
         end
         else
         begin
            active_reg.numerator <= active_reg.numerator - step_word;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         frac_mode_reg <= '0;
         frac_en_reg <= 1'b0;
      end
      else
      begin
         frac_mode_reg <= frac_byte[lddfr_pkg::FRAC_MODE_LSB +: lddfr_pkg::FRAC_MODE_W];
         frac_en_reg <= frac_byte[lddfr_pkg::FRAC_EN_BIT];
      end
   end

   // ----------------------------------------
   // input choice
   // ----------------------------------------
   // reserved codes 4-7 fold onto low bits; software keeps them out
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         in_sel_reg <= '0;
      end
      else if (register_select_control_reg)
      begin
         in_sel_reg <= manual_input_select[1:0];
      end
      else
      begin
         in_sel_reg <= input_select_pins;
      end
   end

   // ----------------------------------------
   // fast acquire bandwidth
   // ----------------------------------------
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         fast_bw_reg <= 1'b0;
      end
      else
      begin
         fast_bw_reg <= force_fast_acquire || (auto_fast_acquire_enable && loss_of_lock);
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always_comb
   begin
      rd_next = lddfr_pkg::WORD_ZERO;
      if ((rd_idx_reg >= lddfr_pkg::IDX_NUM) && (rd_idx_reg <= lddfr_pkg::IDX_FAST))
      begin
         rd_next[7:0] = cfg_byte[int'(rd_idx_reg - lddfr_pkg::IDX_NUM)];
         if (rd_idx_reg == lddfr_pkg::IDX_UPD)
         begin
            rd_next[lddfr_pkg::UPD_BIT] = upd_pend_reg;
         end
      end
      else if (rd_idx_reg == lddfr_pkg::IDX_SELCTL)
      begin
         rd_next[lddfr_pkg::SELCTL_BIT] = register_select_control_reg;
      end
      else if (rd_idx_reg == lddfr_pkg::IDX_STATUS)
      begin
         rd_next[lddfr_pkg::ST_FAST_BIT] = fast_bw_reg;
         rd_next[lddfr_pkg::ST_INSEL_LSB +: 2] = in_sel_reg;
         rd_next[lddfr_pkg::ST_LOL_BIT] = loss_of_lock;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign hrdata = hrdata_reg;
   assign hreadyout = hready_reg;
   assign hresp = hresp_reg;
   assign active_divider = active_reg;
   assign fractional_mode_field = frac_mode_reg;
   assign fractional_enable = frac_en_reg;
   assign selected_input = in_sel_reg;
   assign fast_bandwidth = fast_bw_reg;

endmodule : lddfr_top

// ==== verification/lddfr_monitor.sv ====
`timescale 1ns/1ps
module lddfr_monitor (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic soft_reset_req,
   input wire logic loss_of_lock,
   input wire logic [1:0] input_select_pins,
   input wire logic frequency_increment,
   input wire logic frequency_decrement,
   input wire lddfr_pkg::lddfr_divider_t active_divider,
   input wire logic [3:0] fractional_mode_field,
   input wire logic fractional_enable,
   input wire logic [1:0] selected_input,
   input wire logic fast_bandwidth
);
   // ----------------------------------------
   // shadows of control bits, rebuilt from bus writes
   // ----------------------------------------
   logic wr_ph, sel_ctl_reg, smask_reg, upd_reg;
   logic [13:0] wr_idx;
   logic [1:0] insel_reg, fast_reg;
   logic [4:0] frac_reg;
   wire take = hsel && hready && htrans == lddfr_pkg::HTRANS_NONSEQ;
   wire wdone = wr_ph && hready;
   wire [1:0] exp_sel = sel_ctl_reg ? insel_reg : input_select_pins;
   wire exp_fast = fast_reg[1] | (fast_reg[0] & loss_of_lock);
   wire cause = upd_reg | soft_reset_req | frequency_increment | frequency_decrement;
   wire held = !soft_reset_req && !upd_reg;
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_ph <= 1'b0;
         wr_idx <= '0;
         upd_reg <= 1'b0;
         {sel_ctl_reg, insel_reg, fast_reg, smask_reg, frac_reg} <= '0;
      end
      else
      begin
         wr_ph <= take && hwrite;
         if (take) wr_idx <= haddr[15:2];
         upd_reg <= wdone && wr_idx == lddfr_pkg::IDX_UPD && hwdata[0];
         if (wdone && wr_idx == lddfr_pkg::IDX_SELCTL) sel_ctl_reg <= hwdata[0];
         if (wdone && wr_idx == lddfr_pkg::IDX_INSEL) insel_reg <= hwdata[1:0];
         if (wdone && wr_idx == lddfr_pkg::IDX_FAST) fast_reg <= hwdata[1:0];
         if (wdone && wr_idx == lddfr_pkg::IDX_SMASK) smask_reg <= hwdata[0];
         if (wdone && wr_idx == lddfr_pkg::IDX_FRAC) frac_reg <= hwdata[4:0];
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   chk_resp_okay: assert property (hresp == lddfr_pkg::HRESP_OKAY)
      else $error("hresp not okay");
   chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   chk_rdata_hold: assert property ($changed(hrdata) |-> $rose(hreadyout))
      else $error("hrdata moved outside a read");
   chk_frac_copy: assert property (wdone && wr_idx == lddfr_pkg::IDX_FRAC |-> ##[1:2]
      {fractional_enable, fractional_mode_field} == frac_reg) else $error("fractional outputs wrong");
   chk_input_choice: assert property ($past(nrst) |-> selected_input == $past(exp_sel))
      else $error("selected input wrong");
   chk_fast_bw: assert property ($past(nrst) |-> fast_bandwidth == $past(exp_fast))
      else $error("fast bandwidth wrong");
   chk_div_cause: assert property ($past(nrst) && $changed(active_divider) |-> $past(cause))
      else $error("divider moved without cause");
   chk_step_masked: assert property ((frequency_increment ^ frequency_decrement) && smask_reg && held
      |=> $stable(active_divider)) else $error("masked step applied");
   chk_step_both: assert property (frequency_increment && frequency_decrement && held
      |=> $stable(active_divider)) else $error("conflicting step applied");
   cov_read: cover property (take && !hwrite);
   cov_soft: cover property (soft_reset_req);
   cov_fast: cover property ($rose(fast_bandwidth));
   cov_update: cover property (upd_reg);
endmodule : lddfr_monitor

bind lddfr_top lddfr_monitor u_lddfr_monitor (.mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
   .hready, .hrdata, .hreadyout, .hresp, .soft_reset_req, .loss_of_lock, .input_select_pins, .frequency_increment,
   .frequency_decrement, .active_divider, .fractional_mode_field, .fractional_enable, .selected_input,
   .fast_bandwidth);

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   // ----------------------------------------
   // signals and design
   // ----------------------------------------
   typedef struct {logic [13:0] idx; logic [31:0] wd; logic [31:0] ex;} lddfr_row_t;
   logic mclk, nrst, hsel, hwrite, hready, hreadyout, hresp, soft_reset_req, loss_of_lock;
   logic frequency_increment, frequency_decrement, fractional_enable, fast_bandwidth;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, input_select_pins, selected_input;
   logic [2:0] hsize;
   logic [3:0] fractional_mode_field, fc [5];
   lddfr_pkg::lddfr_divider_t active_divider;
   logic [55:0] num, step;
   logic [31:0] den;
   int bad_count, n_tests;
   lddfr_row_t rows [8];
   assign hready = hreadyout;
   lddfr_top u_lddfr_top (.mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .soft_reset_req, .loss_of_lock, .input_select_pins, .frequency_increment,
      .frequency_decrement, .active_divider, .fractional_mode_field, .fractional_enable, .selected_input,
      .fast_bandwidth);
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task complete_run;
      if (bad_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word
   task chk_div(input lddfr_pkg::lddfr_divider_t e);
      n_tests++;
      if (active_divider !== e)
      begin
         bad_count++;
         $display("Error active_divider expected %h seen %h", e, active_divider);
      end
   endtask : chk_div
   task tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   // waits for hready high at a falling edge, then the next rising edge; slow answers hit the 16-cycle bound
   task wait_rdy(output logic [31:0] d);
      int k;
      k = 0;
      @(negedge mclk);
      while (hreadyout !== 1'b1 && k < 16)
      begin
         k++;
         @(negedge mclk);
      end
      if (k == 16)
      begin
         bad_count++;
         $display("Error hreadyout expected 1 seen %b", hreadyout);
         complete_run;
      end
      d = hrdata;
      @(posedge mclk);
   endtask : wait_rdy
   task bus(input logic w, input logic [13:0] idx, input logic [31:0] wd, output logic [31:0] d);
      hsel <= 1'b1;
      htrans <= lddfr_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {16'h0000, idx, 2'h0};
      wait_rdy(d);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy(d);
   endtask : bus
   task wr(input logic [13:0] idx, input logic [31:0] wd);
      bus(1'b1, idx, wd, rd);
   endtask : wr
   task rd_chk(input logic [13:0] idx, input logic [31:0] ex);
      bus(1'b0, idx, 32'h0000_0000, rd);
      chk_word("hrdata", ex, rd);
   endtask : rd_chk
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      {nrst, hsel, hwrite, soft_reset_req, loss_of_lock, frequency_increment, frequency_decrement} = '0;
      {haddr, hwdata, htrans, input_select_pins} = '0;
      hsize = 3'h2;
      bad_count = 0;
      n_tests = 0;
      rows = '{'{14'h0700, 32'hFF, 32'h00}, '{lddfr_pkg::IDX_FRAC, 32'hFB, 32'h3B},
         '{lddfr_pkg::IDX_SMASK, 32'hFF, 32'h01}, '{lddfr_pkg::IDX_INSEL, 32'hFB, 32'h03},
         '{lddfr_pkg::IDX_FAST, 32'hFF, 32'h03}, '{lddfr_pkg::IDX_SELCTL, 32'hFF, 32'h01},
         '{lddfr_pkg::IDX_DEN + 14'h3, 32'h15A, 32'h5A}, '{lddfr_pkg::IDX_STEP + 14'h6, 32'hC3, 32'hC3}};
      fc = '{4'h7, 4'h4, 4'h9, 4'hB, 4'h2};
      num = 56'h12_3456_789A_BC00;
      den = 32'h0000_0100;
      step = 56'h01_0000_0000_0101;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      foreach (rows[i]) rd_chk(rows[i].idx, 32'h0000_0000);
      foreach (rows[i])
      begin
         wr(rows[i].idx, rows[i].wd);
         rd_chk(rows[i].idx, rows[i].ex);
      end
      wr(lddfr_pkg::IDX_SMASK, 32'h0);
      for (int i = 0; i < 7; i++) wr(lddfr_pkg::IDX_NUM + 14'(i), {24'h0, num[8*i+:8]});
      for (int i = 0; i < 4; i++) wr(lddfr_pkg::IDX_DEN + 14'(i), {24'h0, den[8*i+:8]});
      for (int i = 0; i < 7; i++) wr(lddfr_pkg::IDX_STEP + 14'(i), {24'h0, step[8*i+:8]});
      chk_div('0);
      wr(lddfr_pkg::IDX_UPD, 32'h1);
      tick(1);
      chk_div({num, den});
      rd_chk(lddfr_pkg::IDX_UPD, 32'h0);
      frequency_increment <= 1'b1;
      tick(1);
      frequency_increment <= 1'b0;
      chk_div({num + step, den});
      frequency_decrement <= 1'b1;
      tick(2);
      frequency_decrement <= 1'b0;
      chk_div({num - step, den});
      {frequency_increment, frequency_decrement} <= 2'h3;
      tick(1);
      {frequency_increment, frequency_decrement} <= 2'h0;
      wr(lddfr_pkg::IDX_SMASK, 32'h1);
      frequency_increment <= 1'b1;
      tick(1);
      frequency_increment <= 1'b0;
      chk_div({num - step, den});
      wr(lddfr_pkg::IDX_NUM, 32'h0);
      soft_reset_req <= 1'b1;
      tick(1);
      soft_reset_req <= 1'b0;
      chk_div({num & ~56'hFF, den});
      wr(lddfr_pkg::IDX_FRAC, 32'h3B);
      tick(1);
      chk_word("fractional", 32'h1B, {27'h0, fractional_enable, fractional_mode_field});
      wr(lddfr_pkg::IDX_FRAC, 32'h2B);
      tick(1);
      chk_word("fractional", 32'h0B, {27'h0, fractional_enable, fractional_mode_field});
      wr(lddfr_pkg::IDX_SELCTL, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         input_select_pins <= 2'(i);
         tick(2);
         chk_word("selected_input", i, {30'h0, selected_input});
      end
      wr(lddfr_pkg::IDX_SELCTL, 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         wr(lddfr_pkg::IDX_INSEL, i);
         input_select_pins <= ~2'(i);
         tick(2);
         chk_word("selected_input", i, {30'h0, selected_input});
      end
      // fc rows: force, auto, loss of lock, expected bandwidth
      foreach (fc[i])
      begin
         wr(lddfr_pkg::IDX_FAST, {30'h0, fc[i][3:2]});
         loss_of_lock <= fc[i][1];
         tick(2);
         chk_word("fast_bandwidth", {31'h0, fc[i][0]}, {31'h0, fast_bandwidth});
      end
      // status view: lock lost, input 3 chosen, normal bandwidth
      rd_chk(lddfr_pkg::IDX_STATUS, 32'h0000_000E);
      nrst <= 1'b0;
      tick(1);
      chk_div('0);
      chk_word("fast_bandwidth", 32'h0, {31'h0, fast_bandwidth});
      chk_word("hreadyout", 32'h1, {31'h0, hreadyout});
      chk_word("hresp", 32'h0, {31'h0, hresp});
      nrst <= 1'b1;
      tick(1);
      rd_chk(lddfr_pkg::IDX_FRAC, 32'h0);
      complete_run;
   end
endmodule : testbench
